/* include/tbt_pkg.sv */
`default_nettype none
package tbt_pkg;
    // widths
    localparam int CNT_W = 16; // raw count and baseline width
    localparam int SNS_N = 4; // number of sensors
    localparam int SNS_W = 2; // sensor index width
    localparam int ACC_W = 20; // baseline accumulator width (count + fraction)
    localparam int FLT_SH = 4; // low-pass shift: baseline moves 1/16 per scan
    localparam int WIN_W = 6; // noise window scan counter width
    // constants
    localparam logic [WIN_W-1:0] NOISE_WIN = 6'h3F; // last window count: a window closes on every 64th off-state scan
    localparam logic [CNT_W-1:0] SNR_MIN = 16'h0005; // minimum signal to noise ratio
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000; // reset value of counts
    localparam logic [CNT_W-1:0] RST_NTHR = 16'h0014; // reset noise threshold
    localparam logic [CNT_W-1:0] RST_FTHR = 16'h0050; // reset finger threshold
    localparam logic [CNT_W-1:0] RST_NMIN = 16'hFFFF; // reset window minimum, full scale, at or above any count
endpackage
`default_nettype wire

/* rtl/tbt_core.sv */
// Overview of operation
// (RL1) baseline is low-pass filtered raw count
// (RL2) signal equals raw count minus baseline
// (RL3) thresholds are offsets above the baseline
// (RL4) above noise threshold: freeze baseline, report difference
// (RL5) below noise threshold: update baseline, signal zero
// (RL6) on when signal reaches finger plus hysteresis
// (RL7) off when signal reaches finger minus hysteresis
// (RL8) between limits hold state; reset is off
// (RL9) auto mode measures noise, adjusts thresholds
// (RL10) auto thresholds keep signal/noise at least five
// (RL11) snr signal is on average minus off average
// (RL12) noise is off-state max minus min
`timescale 1ns/1ns
`default_nettype none
module tbt_core
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic raw_valid,
    input wire logic [tbt_pkg::SNS_W-1:0] raw_sensor,
    input wire logic [tbt_pkg::CNT_W-1:0] raw_count,
    input wire logic auto_mode,
    input wire logic [tbt_pkg::CNT_W-1:0] noise_thr_cfg,
    input wire logic [tbt_pkg::CNT_W-1:0] finger_thr_cfg,
    input wire logic [tbt_pkg::CNT_W-1:0] hysteresis_cfg,
    input wire logic [tbt_pkg::SNS_W-1:0] sel_sensor,
    output logic [tbt_pkg::SNS_N-1:0] sensor_on,
    output logic out_valid,
    output logic [tbt_pkg::SNS_W-1:0] out_sensor,
    output logic [tbt_pkg::CNT_W-1:0] out_diff,
    output logic [tbt_pkg::CNT_W-1:0] sel_baseline,
    output logic [tbt_pkg::CNT_W-1:0] sel_noise,
    output logic [tbt_pkg::CNT_W-1:0] sel_signal,
    output logic [tbt_pkg::CNT_W-1:0] sel_noise_thr,
    output logic [tbt_pkg::CNT_W-1:0] sel_finger_thr,
    output logic sel_snr_ok
);
    localparam int CW = tbt_pkg::CNT_W;
    localparam int AW = tbt_pkg::ACC_W;

    // saturating add of two counts
    function automatic logic [CW-1:0] sat_add(input logic [CW-1:0] a, input logic [CW-1:0] b);
        logic [CW:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[CW] ? {CW{1'b1}} : s[CW-1:0];
    endfunction

    // floored subtraction of two counts
    function automatic logic [CW-1:0] sat_sub(input logic [CW-1:0] a, input logic [CW-1:0] b);
        sat_sub = (a > b) ? a - b : tbt_pkg::RST_COUNT;
    endfunction

    // integer count placed over the fraction bits of an accumulator
    function automatic logic [AW-1:0] to_acc(input logic [CW-1:0] c);
        to_acc = {c, {(AW-CW){1'b0}}};
    endfunction

    // whole-count part of an accumulator
    function automatic logic [CW-1:0] acc_count(input logic [AW-1:0] acc);
        acc_count = acc[AW-1 -: CW];
    endfunction

    // one low-pass step: move 1/16 of the gap toward the new count
    function automatic logic [AW-1:0] lp_step(input logic [AW-1:0] acc, input logic [CW-1:0] c);
        lp_step = acc - (acc >> tbt_pkg::FLT_SH) + (to_acc(c) >> tbt_pkg::FLT_SH);
    endfunction

    // noise times the minimum ratio, pinned at full scale
    function automatic logic [CW-1:0] scale_min(input logic [CW-1:0] n);
        logic [2*CW-1:0] p; // full-width product
        p = n * tbt_pkg::SNR_MIN;
        scale_min = (p[2*CW-1:CW] != '0) ? {CW{1'b1}} : p[CW-1:0];
    endfunction

    // auto noise threshold: just over the spread, never under the setting
    function automatic logic [CW-1:0] pick_nthr(input logic [CW-1:0] n, input logic [CW-1:0] cfg);
        logic [CW-1:0] t; // spread plus one count
        t = sat_add(n, 16'h0001);
        pick_nthr = (t > cfg) ? t : cfg;
    endfunction

    // auto finger threshold: lower hysteresis limit at five noise spans
    function automatic logic [CW-1:0] pick_fthr(input logic [CW-1:0] nx5, input logic [CW-1:0] hyst,
        input logic [CW-1:0] cfg);
        pick_fthr = (sat_sub(nx5, hyst) > cfg) ? sat_add(nx5, hyst) : cfg;
    endfunction

    // per-sensor state
    logic [AW-1:0] base_acc [tbt_pkg::SNS_N]; // baseline with fraction bits
    logic base_init [tbt_pkg::SNS_N]; // first scan seeds the baseline
    logic [CW-1:0] nmax [tbt_pkg::SNS_N]; // off-state max in window
    logic [CW-1:0] nmin [tbt_pkg::SNS_N]; // off-state min in window
    logic [CW-1:0] noise [tbt_pkg::SNS_N]; // last measured peak-to-peak noise
    logic [tbt_pkg::WIN_W-1:0] wcnt [tbt_pkg::SNS_N]; // scans in noise window
    logic [AW-1:0] on_avg [tbt_pkg::SNS_N]; // on-state average raw, filtered
    logic [AW-1:0] off_avg [tbt_pkg::SNS_N]; // off-state average raw, filtered
    logic on_seen [tbt_pkg::SNS_N]; // on average has been seeded
    logic off_seen [tbt_pkg::SNS_N]; // off average has been seeded

    // current sensor view
    logic [CW-1:0] base_cur; // current baseline count
    logic [CW-1:0] nthr; // noise threshold offset in use
    logic [CW-1:0] fthr; // finger threshold offset in use
    logic [CW-1:0] diff_raw; // raw minus baseline
    logic above_noise; // raw above baseline plus noise threshold
    logic [CW-1:0] next_diff; // reported difference count
    logic [CW-1:0] on_lim; // upper hysteresis limit
    logic [CW-1:0] off_lim; // lower hysteresis limit
    logic [CW-1:0] auto_nthr; // noise-derived noise threshold
    logic [CW-1:0] auto_fthr; // noise-derived finger threshold
    logic [CW-1:0] noise_x5; // noise scaled by minimum ratio

    // threshold selection and signal forming
    always_comb
    begin
        base_cur = acc_count(base_acc[raw_sensor]);
        noise_x5 = scale_min(noise[raw_sensor]);
        // noise threshold sits just over the measured spread
        auto_nthr = pick_nthr(noise[raw_sensor], noise_thr_cfg); // RL9
        // finger threshold set so the upper hysteresis limit is at least five noise spans off the baseline
        auto_fthr = pick_fthr(noise_x5, hysteresis_cfg, finger_thr_cfg); // RL10
        nthr = auto_mode ? auto_nthr : noise_thr_cfg; // RL9
        fthr = auto_mode ? auto_fthr : finger_thr_cfg; // RL9
        diff_raw = sat_sub(raw_count, base_cur); // RL2
        // compare against baseline-relative level, not an absolute count
        above_noise = raw_count > sat_add(base_cur, nthr); // RL3
        next_diff = above_noise ? diff_raw : tbt_pkg::RST_COUNT; // RL4 RL5
        on_lim = sat_add(fthr, hysteresis_cfg); // RL6
        off_lim = sat_sub(fthr, hysteresis_cfg); // RL7
    end

    // baseline filter, frozen while a touch is suspected
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            // every sensor starts unseeded
            for (int i = 0; i < tbt_pkg::SNS_N; i++)
            begin
                base_acc[i] <= '0;
                base_init[i] <= 1'b0;
            end
        end
        else if (raw_valid)
        begin
            if (!base_init[raw_sensor])
            begin
                // first scan seeds the baseline
                base_acc[raw_sensor] <= to_acc(raw_count); // RL1
                base_init[raw_sensor] <= 1'b1;
            end
            else if (!above_noise)
            begin
                // move 1/16 of the gap toward the raw count
                base_acc[raw_sensor] <= lp_step(base_acc[raw_sensor], raw_count); // RL1 RL5
            end
            // else baseline holds: RL4
        end
    end

    // on/off decision with hysteresis
    always_ff @(posedge clk)
    begin
        if (!nrst)
            sensor_on <= '0; // RL8
        // seeding scan leaves the state alone
        else if (raw_valid && base_init[raw_sensor])
        begin
            if (next_diff >= on_lim)
                sensor_on[raw_sensor] <= 1'b1; // RL6
            else if (next_diff <= off_lim)
                sensor_on[raw_sensor] <= 1'b0; // RL7
            // otherwise state held: RL8
        end
    end

    // per-scan difference output
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            out_valid <= 1'b0;
            out_sensor <= '0;
            out_diff <= tbt_pkg::RST_COUNT;
        end
        else
        begin
            out_valid <= raw_valid;
            // sensor and count only move on a scan
            if (raw_valid)
            begin
                out_sensor <= raw_sensor;
                out_diff <= base_init[raw_sensor] ? next_diff : tbt_pkg::RST_COUNT; // RL2
            end
        end
    end

    // off-state noise measurement over a window of scans
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < tbt_pkg::SNS_N; i++)
            begin
                nmax[i] <= tbt_pkg::RST_COUNT;
                nmin[i] <= tbt_pkg::RST_NMIN; // empty window: any count below full scale is lower
                noise[i] <= tbt_pkg::RST_COUNT;
                wcnt[i] <= '0;
            end
        end
        // only off-state scans of a seeded sensor count
        else if (raw_valid && !sensor_on[raw_sensor] && base_init[raw_sensor])
        begin
            if (wcnt[raw_sensor] == tbt_pkg::NOISE_WIN)
            begin
                // close the window: spread becomes the noise figure
                noise[raw_sensor] <= sat_sub(nmax[raw_sensor], nmin[raw_sensor]); // RL12
                nmax[raw_sensor] <= raw_count;
                nmin[raw_sensor] <= raw_count;
                wcnt[raw_sensor] <= '0;
            end
            else
            begin
                // widen the running max and min
                if (raw_count > nmax[raw_sensor])
                    nmax[raw_sensor] <= raw_count; // RL12
                if (raw_count < nmin[raw_sensor])
                    nmin[raw_sensor] <= raw_count; // RL12
                wcnt[raw_sensor] <= wcnt[raw_sensor] + 1'b1;
            end
        end
    end

    // on and off averages of the raw count
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < tbt_pkg::SNS_N; i++)
            begin
                on_avg[i] <= '0;
                off_avg[i] <= '0;
                on_seen[i] <= 1'b0;
                off_seen[i] <= 1'b0;
            end
        end
        else if (raw_valid && base_init[raw_sensor])
        begin
            if (sensor_on[raw_sensor])
            begin
                on_seen[raw_sensor] <= 1'b1;
                // first on scan seeds, later ones filter
                on_avg[raw_sensor] <= !on_seen[raw_sensor] ? to_acc(raw_count)
                    : lp_step(on_avg[raw_sensor], raw_count); // RL11
            end
            else
            begin
                off_seen[raw_sensor] <= 1'b1;
                // first off scan seeds, later ones filter
                off_avg[raw_sensor] <= !off_seen[raw_sensor] ? to_acc(raw_count)
                    : lp_step(off_avg[raw_sensor], raw_count); // RL11
            end
        end
    end

    // status view of the selected sensor, registered
    logic [CW-1:0] sig_sel; // on average minus off average
    logic [CW-1:0] nx5_sel; // selected noise times minimum ratio
    logic [CW-1:0] nthr_sel; // selected noise threshold
    logic [CW-1:0] fthr_sel; // selected finger threshold
    always_comb
    begin
        sig_sel = (on_seen[sel_sensor] && off_seen[sel_sensor])
            ? sat_sub(acc_count(on_avg[sel_sensor]), acc_count(off_avg[sel_sensor]))
            : tbt_pkg::RST_COUNT; // RL11
        nx5_sel = scale_min(noise[sel_sensor]);
        // same threshold choice as the scan path, for the selected sensor
        nthr_sel = auto_mode ? pick_nthr(noise[sel_sensor], noise_thr_cfg) : noise_thr_cfg; // RL9
        fthr_sel = auto_mode ? pick_fthr(nx5_sel, hysteresis_cfg, finger_thr_cfg) : finger_thr_cfg; // RL10
    end

    // status registers, one cycle behind the selection
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sel_baseline <= tbt_pkg::RST_COUNT;
            sel_noise <= tbt_pkg::RST_COUNT;
            sel_signal <= tbt_pkg::RST_COUNT;
            sel_noise_thr <= tbt_pkg::RST_NTHR;
            sel_finger_thr <= tbt_pkg::RST_FTHR;
            sel_snr_ok <= 1'b0;
        end
        else
        begin
            sel_baseline <= acc_count(base_acc[sel_sensor]);
            sel_noise <= noise[sel_sensor];
            sel_signal <= sig_sel;
            sel_noise_thr <= nthr_sel;
            sel_finger_thr <= fthr_sel;
            sel_snr_ok <= (sig_sel != tbt_pkg::RST_COUNT) && (sig_sel >= nx5_sel); // RL10
        end
    end
endmodule
`default_nettype wire

/* testbench/tbt_conv.sv */
`timescale 1ns/1ns
`default_nettype none
module tbt_conv
(
    input wire logic clk,
    input wire logic go,
    input wire logic [tbt_pkg::SNS_W-1:0] scan_sensor,
    input wire logic [tbt_pkg::CNT_W-1:0] scan_count,
    output logic raw_valid,
    output logic [tbt_pkg::SNS_W-1:0] raw_sensor,
    output logic [tbt_pkg::CNT_W-1:0] raw_count
);
    // one result per scan; stale lines invert so old data never looks valid
    always @(posedge clk)
    begin
        raw_valid <= go;
        raw_sensor <= go ? scan_sensor : ~raw_sensor;
        raw_count <= go ? scan_count : ~raw_count;
    end
endmodule
`default_nettype wire

/* testbench/tbt_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module tbt_monitor
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic raw_valid,
    input wire logic [tbt_pkg::SNS_W-1:0] raw_sensor,
    input wire logic auto_mode,
    input wire logic [tbt_pkg::CNT_W-1:0] noise_thr_cfg,
    input wire logic [tbt_pkg::CNT_W-1:0] finger_thr_cfg,
    input wire logic [tbt_pkg::SNS_N-1:0] sensor_on,
    input wire logic out_valid,
    input wire logic [tbt_pkg::SNS_W-1:0] out_sensor,
    input wire logic [tbt_pkg::CNT_W-1:0] out_diff,
    input wire logic [tbt_pkg::CNT_W-1:0] sel_noise_thr,
    input wire logic [tbt_pkg::CNT_W-1:0] sel_finger_thr
);
    // one clock for all checks; reset disables all but the reset check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // scan taken
    sequence s_take;
        raw_valid;
    endsequence
    // answer for that scan
    sequence s_answer;
        out_valid && out_sensor == $past(raw_sensor);
    endsequence
    a_scan_answer: assert property (s_take |=> s_answer)
        else $error("scan not answered");
    a_no_spurious: assert property (!raw_valid |=> !out_valid)
        else $error("answer without scan");
    a_state_hold: assert property ($changed(sensor_on) |-> out_valid)
        else $error("state moved without scan");
    a_zero_off: assert property (out_valid && out_diff == 0 |-> !sensor_on[out_sensor])
        else $error("on with zero difference");
    a_diff_stands: assert property (!out_valid |-> $stable(out_diff))
        else $error("difference moved between scans");
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=> sensor_on == 0 && !out_valid)
        else $error("reset left state");
    a_nthr_manual: assert property ($past(nrst) && !$past(auto_mode) |-> sel_noise_thr == $past(noise_thr_cfg))
        else $error("manual noise threshold wrong");
    a_nthr_floor: assert property ($past(nrst) |-> sel_noise_thr >= $past(noise_thr_cfg))
        else $error("noise threshold below setting");
    a_fthr_floor: assert property ($past(nrst) |-> sel_finger_thr >= $past(finger_thr_cfg))
        else $error("finger threshold below setting");
endmodule
bind tbt_core tbt_monitor u_tbt_monitor (.*);
`default_nettype wire

/* testbench/touch_baseline_threshold_logic_test.sv */
`timescale 1ns/1ns
`default_nettype none
module touch_baseline_threshold_logic_test;
    logic clk = 0, nrst = 0, go = 0, auto_mode = 0, raw_valid, out_valid, sel_snr_ok; // controls
    logic [1:0] scan_sensor = 0, sel_sensor = 0, raw_sensor, out_sensor; // sensor indices
    logic [15:0] scan_count = 0, raw_count, out_diff, sel_baseline, sel_noise, sel_signal; // counts
    logic [15:0] noise_thr_cfg = 16'h0014, finger_thr_cfg = 16'h0050, hysteresis_cfg = 16'h000A; // settings
    logic [15:0] sel_noise_thr, sel_finger_thr; // live thresholds
    logic [3:0] sensor_on; // per-sensor state
    logic [47:0] r; // row under check
    int bad_count = 0, check_count = 0, cycles = 0; // tallies
    // rows: on bit 36, sensor 33:32, raw 31:16, expected difference 15:0
    logic [47:0] rows [10] = '{48'h0000_03E8_0000, 48'h0001_07D0_0000, 48'h0000_03E8_0000,
        48'h0010_044C_0064, 48'h0011_0834_0064, 48'h0010_0438_0050, 48'h0000_042E_0046,
        48'h0000_0438_0050, 48'h0010_0442_005A, 48'h0000_03FC_0000};
    tbt_conv u_tbt_conv (.*);
    tbt_core u_tbt_core (.*);
    // 4 ns clock
    always #2 clk = ~clk;
    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            bad_count++;
            end_of_test;
        end
    end
    // compare and tally
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // one scan request, held for one edge
    task scan(input logic [1:0] s, input logic [15:0] c);
        go = 1;
        scan_sensor = s;
        scan_count = c;
        @(posedge clk);
        #1;
    endtask
    // no request for n edges
    task idle(input int n);
        go = 0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    // counts and verdict
    task end_of_test;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial
    begin
        idle(2);
        nrst = 1;
        // back-to-back table, each row checked two edges after its request
        for (int i = 0; i < 12; i++)
        begin
            if (i > 1)
            begin
                r = rows[i-2];
                check(out_valid, 1);
                check(out_sensor, r[33:32]);
                check(out_diff, r[15:0]);
                check(sensor_on[r[33:32]], r[36]);
            end
            if (i < 10)
                scan(rows[i][33:32], rows[i][31:16]);
            else
                idle(1);
        end
        $display("table test done");
        // slow drift moves the baseline only partly
        scan(2, 16'h07D0);
        repeat (16) scan(2, 16'h07E0);
        sel_sensor = 2;
        idle(3);
        check(out_diff, 0);
        check(sel_baseline > 16'h07D0 && sel_baseline < 16'h07E0, 1);
        check(sel_snr_ok, 0);
        $display("drift test done");
        // noise window in automatic mode, then a touch
        auto_mode = 1;
        scan(3, 16'h0BB8);
        for (int k = 0; k < 66; k++)
            scan(3, k[0] ? 16'h0BCB : 16'h0BB8);
        sel_sensor = 3;
        idle(3);
        check(sel_noise, 16'h0013);
        check(sel_noise_thr, 16'h0014);
        check(sel_finger_thr, 16'h0069);
        repeat (16) scan(3, 16'h0C4E);
        idle(3);
        check(sensor_on[3], 1);
        check(sel_signal >= 16'h005F, 1);
        check(sel_snr_ok, 1);
        $display("noise test done");
        // mid-run reset, then first scan only seeds
        nrst = 0;
        idle(2);
        check(sensor_on, 0);
        check(out_diff, 0);
        check(sel_noise_thr, 16'h0014);
        nrst = 1;
        auto_mode = 0;
        scan(3, 16'h0C4E);
        idle(2);
        check(out_diff, 0);
        check(sensor_on[3], 0);
        scan(3, 16'h0CB2);
        idle(2);
        check(out_diff, 16'h0064);
        check(sensor_on[3], 1);
        $display("reset test done");
        end_of_test;
    end
endmodule
`default_nettype wire
